// [rtl/dahm_core.sv]
// Purpose: accumulator moves, shift-in and paired halfword products
// Assumes: issue is synchronous to CLK; the core writes back RES.data to RES.dest
// Notes: one instruction per cycle, result one cycle after acceptance
//
// Summary of operation
// - copy_gpr_upper (function 010001) writes all 64 source bits to the upper half.
// - the upper half of an accumulator is bits 64 to 127 of its storage.
// - copy_gpr_bottom (function 010011) writes all 64 source bits to bits 0 to 63.
// - the two-bit select picks one of four accumulators, number 0 being the legacy pair.
// - reading either half of accumulator 0 while a multiply or divide is pending stalls.
// - shift_in_word is group 011111, sub 11111, function 111000 on the selected accumulator.
// - shift-in moves the sign-extended old bottom word up and the sign-extended source down.
// - shift-in adds 32 to the seven-bit position field in control bits 6..0.
// - paired products are group 011111 function 011000, sub 01100 wrapping, 01110 saturating.
// - each signed lane product is 32 bits and the wrapping form keeps its low 16 bits.
// - the saturating form clamps lanes to 0x7fff or 0x8000.
// - a saturating lane overflow sets control bit 21.
// - paired products leave accumulators 1 to 3 unchanged.
// - only reserved-instruction and dsp-disabled exceptions are raised.
`include "dahm_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module dahm_core (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic ISSUE_VALID,
  input wire dahm_pkg::dahm_issue_t ISSUE,
  output logic ISSUE_READY,
  input wire logic DSP_ENABLE,
  input wire logic MDU_BUSY,
  input wire logic MDU_WR_VALID,
  input wire logic [127:0] MDU_WR_DATA,
  input wire logic RD_VALID,
  input wire logic [1:0] RD_SEL,
  input wire logic RD_UPPER,
  output logic RD_READY,
  output logic [63:0] RD_DATA,
  input wire logic CTL_WR,
  input wire logic [31:0] CTL_WDATA,
  output logic [31:0] CTL,
  output dahm_pkg::dahm_result_t RES
);

  // ****************************************
  // decode
  // ****************************************
  function automatic dahm_pkg::dahm_op_t decode_op(input logic [31:0] ins);
    logic [5:0] grp;
    logic [5:0] fn;
    logic [4:0] sub;
    logic [7:0] zf;
    grp = ins[`DAHM_GRP_HI:`DAHM_GRP_LO];
    fn = ins[`DAHM_FN_HI:`DAHM_FN_LO];
    sub = ins[`DAHM_SUB_HI:`DAHM_SUB_LO];
    zf = ins[`DAHM_ZERO_HI:`DAHM_ZERO_LO];
    // copy ops insist on zero filler fields; any other pattern is reserved
    decode_op = dahm_pkg::OP_RSVD;
    if (grp == `DAHM_GRP_BASE && zf == `DAHM_ZERO_FIELD && sub == `DAHM_ZERO_SUB) begin
      if (fn == `DAHM_FN_UPPER) begin
        decode_op = dahm_pkg::OP_UPPER;
      end else if (fn == `DAHM_FN_BOTTOM) begin
        decode_op = dahm_pkg::OP_BOTTOM;
      end
    end else if (grp == `DAHM_GRP_THREE) begin
      if (fn == `DAHM_FN_SHIFT && sub == `DAHM_SUB_SHIFT && zf == `DAHM_ZERO_FIELD) begin
        decode_op = dahm_pkg::OP_SHIFT;
      end else if (fn == `DAHM_FN_PROD && sub == `DAHM_SUB_PROD) begin
        decode_op = dahm_pkg::OP_PROD;
      end else if (fn == `DAHM_FN_PROD && sub == `DAHM_SUB_PROD_SAT) begin
        decode_op = dahm_pkg::OP_PROD_SAT;
      end
    end
  endfunction : decode_op

  // ****************************************
  // state
  // ****************************************
  // index 0 doubles as the legacy multiply result pair
  logic [127:0] acc [`DAHM_ACC_COUNT];
  logic [127:0] next_acc [`DAHM_ACC_COUNT];
  logic [31:0] next_ctl;
  dahm_pkg::dahm_result_t next_res;
  logic [63:0] next_rd_data;
  dahm_pkg::dahm_op_t op;
  logic [1:0] sel;
  logic accept;
  logic dsp_op;
  logic [31:0] lane_res;
  logic [1:0] lane_ovf;

  assign op = decode_op(ISSUE.instr);
  assign sel = ISSUE.instr[`DAHM_SEL_HI:`DAHM_SEL_LO];

  // shift-in reads the old bottom word, so it waits on a pending legacy result too
  assign ISSUE_READY = !(op == dahm_pkg::OP_SHIFT && sel == `DAHM_LEGACY_SEL && MDU_BUSY);
  assign RD_READY = !(RD_SEL == `DAHM_LEGACY_SEL && MDU_BUSY);
  assign accept = ISSUE_VALID && ISSUE_READY;

  // legacy-pair moves stay legal with the dsp unit switched off
  assign dsp_op = (op == dahm_pkg::OP_SHIFT) || (op == dahm_pkg::OP_PROD) ||
                  (op == dahm_pkg::OP_PROD_SAT) ||
                  ((op == dahm_pkg::OP_UPPER || op == dahm_pkg::OP_BOTTOM) &&
                   sel != `DAHM_LEGACY_SEL);

  // ****************************************
  // paired halfword lanes
  // ****************************************
  // lane 0 is bits 15..0, lane 1 bits 31..16
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_lane
      logic signed [31:0] prod;
      logic ovf;
      logic [15:0] lane;
      assign prod = $signed(ISSUE.operand_a[16*g +: 16]) *
                    $signed(ISSUE.operand_b[16*g +: 16]);
      // fits in 16 signed bits only when bits 31..15 all agree
      assign ovf = !((&prod[31:15]) || !(|prod[31:15]));
      assign lane_ovf[g] = ovf;
      always_comb begin
        if (op == dahm_pkg::OP_PROD_SAT && ovf) begin
          lane = prod[31] ? `DAHM_SAT_NEG : `DAHM_SAT_POS;
        end else begin
          lane = prod[15:0];
        end
      end
      assign lane_res[16*g +: 16] = lane;
    end
  endgenerate

  // ****************************************
  // next values
  // ****************************************
  always_comb begin
    for (int i = 0; i < `DAHM_ACC_COUNT; i++) begin
      next_acc[i] = acc[i];
    end
    next_ctl = CTL;
    next_res = '0;
    next_rd_data = RD_DATA;
    // a multiply result lands in the legacy pair, but a copy or shift-in accepted in the same cycle on accumulator 0 writes over the bits it targets
    if (MDU_WR_VALID) begin
      next_acc[`DAHM_LEGACY_SEL] = MDU_WR_DATA;
    end
    // software write first, hardware updates below take precedence
    if (CTL_WR) begin
      next_ctl = CTL_WDATA;
    end
    // read data holds between reads, so the core may take it late
    if (RD_VALID && RD_READY) begin
      next_rd_data = RD_UPPER ? acc[RD_SEL][`DAHM_UPPER_HI:`DAHM_UPPER_LO]
                              : acc[RD_SEL][`DAHM_BOTTOM_HI:`DAHM_BOTTOM_LO];
    end
    if (accept) begin
      next_res.valid = 1'b1;
      // only products name a register; the rest aim at register zero, which ignores writes
      // an exception leaves every register as it was
      if (op == dahm_pkg::OP_RSVD) begin
        next_res.exc_reserved = 1'b1;
      end else if (dsp_op && !DSP_ENABLE) begin
        next_res.exc_dsp_off = 1'b1;
      end else begin
        case (op)
          dahm_pkg::OP_UPPER: begin
            next_acc[sel][`DAHM_UPPER_HI:`DAHM_UPPER_LO] = ISSUE.operand_a;
          end
          dahm_pkg::OP_BOTTOM: begin
            next_acc[sel][`DAHM_BOTTOM_HI:`DAHM_BOTTOM_LO] = ISSUE.operand_a;
          end
          dahm_pkg::OP_SHIFT: begin
            next_acc[sel] = {{32{acc[sel][31]}}, acc[sel][31:0],
                             {32{ISSUE.operand_a[31]}}, ISSUE.operand_a[31:0]};
            // a start of 96 or more simply wraps in seven bits
            next_ctl[`DAHM_POS_HI:`DAHM_POS_LO] =
              next_ctl[`DAHM_POS_HI:`DAHM_POS_LO] + `DAHM_POS_STEP;
          end
          dahm_pkg::OP_PROD, dahm_pkg::OP_PROD_SAT: begin
            // accumulators are untouched; the legacy pair is kept too
            next_res.dest = ISSUE.instr[`DAHM_DST_HI:`DAHM_DST_LO];
            next_res.data = {{32{lane_res[31]}}, lane_res};
            // sticky: only a control write or reset clears the flag
            if (op == dahm_pkg::OP_PROD_SAT && (|lane_ovf)) begin
              next_ctl[`DAHM_OUFLAG_BIT] = 1'b1;
            end
          end
          default: begin
            next_res.exc_reserved = 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // reset clears all accumulators, the control word and both outputs
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < `DAHM_ACC_COUNT; i++) begin
        acc[i] <= `DAHM_ACC_RESET;
      end
      CTL <= `DAHM_CTL_RESET;
      RES <= '0;
      RD_DATA <= `DAHM_WORD_RESET;
    end else begin
      for (int i = 0; i < `DAHM_ACC_COUNT; i++) begin
        acc[i] <= next_acc[i];
      end
      CTL <= next_ctl;
      RES <= next_res;
      RD_DATA <= next_rd_data;
    end
  end

endmodule : dahm_core
`default_nettype wire

// [pkg/dahm_cfg.svh]
// Purpose: constants for the accumulator move and halfword product datapath
// Assumes: instruction word is 32 bits, registers are 64 bits
// Notes: definitions only
`ifndef DAHM_CFG_SVH
`define DAHM_CFG_SVH

// ****************************************
// instruction fields
// ****************************************
`define DAHM_GRP_HI 31
`define DAHM_GRP_LO 26
`define DAHM_ZERO_HI 20
`define DAHM_ZERO_LO 13
`define DAHM_SEL_HI 12
`define DAHM_SEL_LO 11
`define DAHM_SUB_HI 10
`define DAHM_SUB_LO 6
`define DAHM_FN_HI 5
`define DAHM_FN_LO 0
`define DAHM_DST_HI 15
`define DAHM_DST_LO 11
`define DAHM_GRP_BASE 6'h00
`define DAHM_GRP_THREE 6'h1f
`define DAHM_FN_UPPER 6'h11
`define DAHM_FN_BOTTOM 6'h13
`define DAHM_FN_SHIFT 6'h38
`define DAHM_FN_PROD 6'h18
`define DAHM_SUB_SHIFT 5'h1f
`define DAHM_SUB_PROD 5'h0c
`define DAHM_SUB_PROD_SAT 5'h0e
`define DAHM_ZERO_FIELD 8'h00
`define DAHM_ZERO_SUB 5'h00

// ****************************************
// accumulator and control layout
// ****************************************
`define DAHM_ACC_COUNT 4
`define DAHM_UPPER_HI 127
`define DAHM_UPPER_LO 64
`define DAHM_BOTTOM_HI 63
`define DAHM_BOTTOM_LO 0
`define DAHM_LEGACY_SEL 2'h0
`define DAHM_POS_HI 6
`define DAHM_POS_LO 0
`define DAHM_POS_STEP 7'h20
`define DAHM_OUFLAG_BIT 21
`define DAHM_SAT_POS 16'h7fff
`define DAHM_SAT_NEG 16'h8000
`define DAHM_ACC_RESET 128'h0
`define DAHM_CTL_RESET 32'h0
`define DAHM_WORD_RESET 64'h0

`endif

// [pkg/dahm_pkg.sv]
// Purpose: types for the accumulator move and halfword product datapath
// Assumes: constants come from dahm_cfg.svh
// Notes: nothing here is imported; users write dahm_pkg::name
`default_nettype none
package dahm_pkg;

  // ****************************************
  // decoded operations
  // ****************************************
  typedef enum logic [2:0] {
    OP_NONE,
    OP_UPPER,
    OP_BOTTOM,
    OP_SHIFT,
    OP_PROD,
    OP_PROD_SAT,
    OP_RSVD
  } dahm_op_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [31:0] instr;
    logic [63:0] operand_a;
    logic [63:0] operand_b;
  } dahm_issue_t;

  typedef struct packed {
    logic valid;
    logic exc_reserved;
    logic exc_dsp_off;
    logic [4:0] dest;
    logic [63:0] data;
  } dahm_result_t;

endpackage : dahm_pkg
`default_nettype wire

// [verification/dahm_mdu_model.sv]
// Purpose: multiply unit stand-in feeding accumulator 0
// Assumes: one start at a time
// Notes: busy for LAT cycles, with one write pulse in the last of them
`timescale 1ns/1ns
`default_nettype none
module dahm_mdu_model #(parameter int LAT = 3) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic start,
  input wire logic [127:0] data,
  output logic busy,
  output logic wr_valid,
  output logic [127:0] wr_data
);
  int cnt;
  always_ff @(posedge CLK) begin
    if (SRST) cnt <= 0;
    else if (start) cnt <= LAT;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign busy = cnt > 0;
  assign wr_valid = cnt == 1;
  // inverted outside the pulse so a stale result never looks valid
  assign wr_data = (cnt == 1) ? data : ~data;
endmodule : dahm_mdu_model
`default_nettype wire

// [verification/dahm_core_properties.sv]
// Purpose: port-level properties of dahm_core
// Assumes: one clock, synchronous reset
// Notes: decode mirrors the instruction fields
`timescale 1ns/1ns
`default_nettype none
module dahm_core_chk (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic ISSUE_VALID,
  input wire dahm_pkg::dahm_issue_t ISSUE,
  input wire logic ISSUE_READY,
  input wire logic DSP_ENABLE,
  input wire logic MDU_BUSY,
  input wire logic RD_VALID,
  input wire logic [1:0] RD_SEL,
  input wire logic RD_READY,
  input wire logic CTL_WR,
  input wire logic [31:0] CTL,
  input wire dahm_pkg::dahm_result_t RES
);
  // ****
  // decode
  // ****
  logic take, g3, shf, prod, sat, ovf;
  logic signed [31:0] p0, p1;
  logic [6:0] pos;
  logic [31:0] wrap;
  assign pos = CTL[6:0];
  assign wrap = {p1[15:0], p0[15:0]};
  // control writes excluded: they race the hardware update
  assign take = ISSUE_VALID && ISSUE_READY && DSP_ENABLE && !CTL_WR;
  assign g3 = ISSUE.instr[31:26] == 6'h1f;
  assign shf = g3 && ISSUE.instr[20:13] == 8'h00 && ISSUE.instr[10:0] == {5'h1f, 6'h38};
  assign prod = g3 && ISSUE.instr[10:0] == {5'h0c, 6'h18};
  assign sat = g3 && ISSUE.instr[10:0] == {5'h0e, 6'h18};
  assign p0 = $signed(ISSUE.operand_a[15:0]) * $signed(ISSUE.operand_b[15:0]);
  assign p1 = $signed(ISSUE.operand_a[31:16]) * $signed(ISSUE.operand_b[31:16]);
  assign ovf = p0 > 32767 || p0 < -32768 || p1 > 32767 || p1 < -32768;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  a_read_interlock: assert property (RD_VALID && RD_SEL == 2'h0 && MDU_BUSY |-> !RD_READY)
    else $error("accumulator 0 read not stalled");
  a_shift_pos: assert property (take && shf && pos <= 7'h20 |=> pos == $past(pos) + 7'h20)
    else $error("position not advanced by 32");
  a_sat_flag: assert property (take && sat && ovf |=> CTL[21])
    else $error("overflow flag not set");
  a_wrap_lanes: assert property (take && prod |=>
    RES.data[31:0] == $past(wrap)) else $error("wrapped lanes wrong");
  a_clamp_pos: assert property (take && sat && p0 > 32767 |=> RES.data[15:0] == 16'h7fff)
    else $error("positive clamp wrong");
  a_clamp_neg: assert property (take && sat && p1 < -32768 |=> RES.data[31:16] == 16'h8000)
    else $error("negative clamp wrong");
  a_prod_sext: assert property (take && (prod || sat) |=>
    RES.data[63:32] == {32{RES.data[31]}}) else $error("product not sign-extended");
  a_legal_quiet: assert property (take && (shf || prod || sat) |=>
    RES.valid && !RES.exc_reserved && !RES.exc_dsp_off) else $error("exception on legal op");
  c_shift: cover property (take && shf);
  c_sat_ovf: cover property (take && sat && ovf);
  c_stall: cover property (RD_VALID && !RD_READY);
endmodule : dahm_core_chk
bind dahm_core dahm_core_chk u_chk (.CLK, .SRST, .ISSUE_VALID, .ISSUE, .ISSUE_READY,
  .DSP_ENABLE, .MDU_BUSY, .RD_VALID, .RD_SEL, .RD_READY, .CTL_WR, .CTL, .RES);
`default_nettype wire

// [verification/testbench.sv]
// Purpose: self-checking bench for dahm_core
// Assumes: result and read data settle one edge after acceptance
// Notes: mdu stand-in drives the legacy result path
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic CLK = 0, SRST = 1, ISSUE_VALID = 0, DSP_ENABLE = 1, RD_VALID = 0, RD_UPPER = 0;
  logic CTL_WR = 0, go = 0, ISSUE_READY, RD_READY, MDU_BUSY, MDU_WR_VALID;
  logic [1:0] RD_SEL = 0;
  logic [31:0] CTL_WDATA = 0, CTL;
  logic [63:0] RD_DATA, d;
  logic [127:0] MDU_WR_DATA;
  dahm_pkg::dahm_issue_t ISSUE = '0;
  dahm_pkg::dahm_result_t RES, res;
  int err_count = 0, checks = 0, cyc = 0;
  always #50 CLK = ~CLK;
  dahm_core u_dut (.CLK, .SRST, .ISSUE_VALID, .ISSUE, .ISSUE_READY, .DSP_ENABLE, .MDU_BUSY,
    .MDU_WR_VALID, .MDU_WR_DATA, .RD_VALID, .RD_SEL, .RD_UPPER, .RD_READY, .RD_DATA,
    .CTL_WR, .CTL_WDATA, .CTL, .RES);
  dahm_mdu_model u_mdu (.CLK, .SRST, .start(go), .data({64'h1111, 64'h2222}),
    .busy(MDU_BUSY), .wr_valid(MDU_WR_VALID), .wr_data(MDU_WR_DATA));
  // ****
  // bus tasks
  // ****
  task automatic issue(input logic [31:0] i, input logic [63:0] a, input logic [63:0] b);
    int n = 0;
    ISSUE = {i, a, b};
    ISSUE_VALID = 1;
    @(negedge CLK);
    while (ISSUE_READY !== 1'b1 && n < 20) begin
      @(negedge CLK);
      n++;
    end
    if (n >= 20) begin
      err_count++;
    end
    @(posedge CLK);
    #1;
    ISSUE_VALID = 0;
    res = RES;
    @(posedge CLK);
    #1;
  endtask : issue
  task automatic rd(input logic [1:0] s, input logic u);
    int n = 0;
    RD_VALID = 1;
    RD_SEL = s;
    RD_UPPER = u;
    @(negedge CLK);
    while (RD_READY !== 1'b1 && n < 20) begin
      @(negedge CLK);
      n++;
    end
    if (n >= 20) begin
      err_count++;
    end
    @(posedge CLK);
    #1;
    RD_VALID = 0;
    d = RD_DATA;
    @(posedge CLK);
    #1;
  endtask : rd
  function automatic logic [31:0] mv(input logic [5:0] f, input logic [1:0] s);
    return {6'h00, 5'h01, 8'h00, s, 5'h00, f};
  endfunction : mv
  function automatic logic [31:0] mp(input logic [4:0] k);
    return {6'h1f, 5'h01, 5'h02, 5'h03, k, 6'h18};
  endfunction : mp
  task automatic t_copy();
    for (int s = 0; s < 4; s++) begin
      issue(mv(6'h11, s[1:0]), 64'hfedc_ba98_7654_3210 ^ 64'(s), 64'h0);
      issue(mv(6'h13, s[1:0]), 64'h8000_0000_0000_0001 + 64'(s), 64'h0);
    end
    for (int s = 0; s < 4; s++) begin
      rd(s[1:0], 1'b1);
      `CHK(d, 64'hfedc_ba98_7654_3210 ^ 64'(s))
      rd(s[1:0], 1'b0);
      `CHK(d, 64'h8000_0000_0000_0001 + 64'(s))
    end
    $display("copy end");
  endtask : t_copy
  task automatic t_shift();
    CTL_WR = 1;
    @(posedge CLK);
    #1;
    CTL_WR = 0;
    issue(mv(6'h13, 2'h1), 64'h0000_0000_8000_0001, 64'h0);
    issue({6'h1f, 5'h01, 8'h00, 2'h1, 5'h1f, 6'h38}, 64'h1234_5678_7fff_fff0, 64'h0);
    `CHK(CTL[6:0], 7'h20)
    `CHK(res.exc_reserved, 1'b0)
    rd(2'h1, 1'b1);
    `CHK(d, 64'hffff_ffff_8000_0001)
    rd(2'h1, 1'b0);
    `CHK(d, 64'h0000_0000_7fff_fff0)
    issue({6'h1f, 5'h01, 8'h00, 2'h1, 5'h1f, 6'h38}, 64'h0, 64'h0);
    `CHK(CTL[6:0], 7'h40)
    $display("shift end");
  endtask : t_shift
  task automatic t_prod();
    issue(mp(5'h0c), 64'h7fff_0003, 64'h0002_fffe);
    `CHK(res.data, 64'hffff_ffff_fffe_fffa)
    `CHK(res.valid, 1'b1)
    `CHK(res.dest, 5'h03)
    `CHK(CTL[21], 1'b0)
    issue(mp(5'h0e), 64'h7fff_0003, 64'h0002_fffe);
    `CHK(res.data, 64'h0000_0000_7fff_fffa)
    `CHK(CTL[21], 1'b1)
    issue(mp(5'h0e), 64'h8000_0001, 64'h0002_0005);
    `CHK(res.data, 64'hffff_ffff_8000_0005)
    issue(mp(5'h0e), 64'h0001_4000, 64'h0001_0004);
    `CHK(res.data, 64'h0000_0000_0001_7fff)
    rd(2'h1, 1'b1);
    `CHK(d, 64'h0000_0000_7fff_fff0)
    $display("product end");
  endtask : t_prod
  task automatic t_exc();
    DSP_ENABLE = 0;
    issue(mp(5'h0c), 64'h1, 64'h1);
    `CHK(res.exc_dsp_off, 1'b1)
    DSP_ENABLE = 1;
    issue({6'h00, 5'h01, 8'h00, 2'h1, 5'h01, 6'h11}, 64'h5, 64'h0);
    `CHK(res.exc_reserved, 1'b1)
    rd(2'h1, 1'b1);
    `CHK(d, 64'h0000_0000_7fff_fff0)
    $display("exception end");
  endtask : t_exc
  task automatic t_stall();
    go = 1;
    @(posedge CLK);
    #1;
    go = 0;
    RD_SEL = 2'h0;
    @(negedge CLK);
    `CHK(RD_READY, 1'b0)
    @(posedge CLK);
    #1;
    // the accumulator 0 read stalls until the pending result has been written
    rd(2'h0, 1'b0);
    `CHK(d, 64'h2222)
    go = 1;
    @(posedge CLK);
    #1;
    go = 0;
    ISSUE = {{6'h1f, 5'h01, 8'h00, 2'h0, 5'h1f, 6'h38}, 64'h5, 64'h0};
    @(negedge CLK);
    `CHK(ISSUE_READY, 1'b0)
    @(posedge CLK);
    #1;
    issue({6'h1f, 5'h01, 8'h00, 2'h0, 5'h1f, 6'h38}, 64'h5, 64'h0);
    rd(2'h0, 1'b1);
    `CHK(d, 64'h2222)
    rd(2'h0, 1'b0);
    `CHK(d, 64'h5)
    $display("stall end");
  endtask : t_stall
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(posedge CLK);
    #1;
    SRST = 0;
    t_copy();
    t_shift();
    t_prod();
    t_exc();
    t_stall();
    test_done();
  end
endmodule : testbench
`default_nettype wire
